// ===== verilog/bgi_pkg.sv
/*
 general interrupt status and mask block: constants, offsets, field layouts.
 assumes a 32-bit AHB-Lite register bus; each register sits in one aligned word.
*/
`default_nettype none
package bgi_pkg;
   // ====================================================================
   // register indices as printed, byte address is four times the index
   localparam logic [7:0] IDX_STATUS_FIRST = 8'hC0;
   localparam logic [7:0] IDX_MASK_FIRST = 8'hC1;
   localparam logic [7:0] IDX_STATUS_SECOND = 8'hC2;
   localparam logic [7:0] IDX_MASK_SECOND = 8'hC3;
   localparam logic [7:0] IDX_IRQ_PENDING = 8'hC4;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'hC5;
   // ====================================================================
   // field positions
   localparam int POS_CASCADE = 7;
   localparam int POS_CTRL_IRQ = 0;
   localparam int POS_LATE = 2;
   localparam int POS_TIMEOUT = 1;
   // ====================================================================
   // reset values
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [1:0] RST_EVT = 2'h0;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
   // ====================================================================
   // AHB-Lite codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic HRESP_OKAY = 1'b0;
   // latched address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] index;
   } bgi_aphase_t;
endpackage
`default_nettype wire

// ===== verilog/bgi_top.sv
/*
 general interrupt status/mask registers with second-level cascade, plus a
 sticky event register and interrupt line. assumes event inputs are one-cycle
 pulses from logic on CLOCK_I; sync loss and internal reset are such pulses too.
*/
// Register access over AHB-Lite was decided locally.
// Behaviour
// R1 - cascade bit shows any unmasked second-level flag
// R2 - bit 0 follows combined controller interrupt
// R3 - first mask bit gates controller interrupt
// R4 - first mask cleared by reset, sync loss
// R5 - late read response sets late flag
// R6 - indirect fallback read sets late flag
// R7 - bridge access timeout sets timeout flag
// R8 - timeout generation follows its configuration enable
// R9 - second-level flags clear by writing one
// R10 - second-level flags survive sync loss reset
// R11 - late enable bit gates, cleared on loss
// R12 - timeout enable bit gates timeout flag
// R13 - previous-read-late status sets late flag
// R14 - reserved bits read zero, fields reset zero
`timescale 1ns/1ps
`default_nettype none
module bgi_top
   import bgi_pkg::*;
(
   input wire logic CLOCK_I,
   input wire logic RSTN_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire logic CTRL_IRQ_I,
   input wire logic LAST_LATE_I,
   input wire logic BRIDGE_TIMEOUT_I,
   input wire logic TIMEOUT_ENABLE_I,
   input wire logic SYNC_LOSS_I,
   input wire logic INTERNAL_RESET_I,
   output logic IRQ_O
);
   // ====================================================================
   // bus slave
   bgi_aphase_t aphase;
   logic wr_status_second, wr_mask_first, wr_mask_second, wr_pending, wr_enable;
   logic [7:0] wbyte;
   logic late_response_flag, timeout_flag;
   logic combined_controller_irq_enable, late_response_enable, timeout_enable;
   logic second_level_cascade_flag, combined_controller_irq_flag;
   logic [1:0] pending, enable;
   logic late_evt, timeout_evt, mask_clear;
   logic [7:0] status_first, status_second, mask_first, mask_second;
   logic rd_phase, rd_ready, rd_capture;

   always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         aphase <= '0;
      end else if (HREADY_I) begin
         aphase.valid <= HSEL_I && (HTRANS_I == HTRANS_NONSEQ || HTRANS_I == HTRANS_SEQ)
                         && HADDR_I[1:0] == 2'h0 && HADDR_I[31:10] == 22'h00_0000;
         aphase.write <= HWRITE_I;
         aphase.index <= HADDR_I[9:2];
      end
   end

   assign HREADYOUT_O = !rd_capture;
   assign HRESP_O = HRESP_OKAY;
   assign wbyte = HWDATA_I[7:0];
   assign wr_status_second = aphase.valid && aphase.write && aphase.index == IDX_STATUS_SECOND;
   assign wr_mask_first = aphase.valid && aphase.write && aphase.index == IDX_MASK_FIRST;
   assign wr_mask_second = aphase.valid && aphase.write && aphase.index == IDX_MASK_SECOND;
   assign wr_pending = aphase.valid && aphase.write && aphase.index == IDX_IRQ_PENDING;
   assign wr_enable = aphase.valid && aphase.write && aphase.index == IDX_IRQ_ENABLE;

   // ====================================================================
   // event sources
   assign late_evt = LAST_LATE_I; // R5 R6 R13
   assign timeout_evt = BRIDGE_TIMEOUT_I && TIMEOUT_ENABLE_I; // R7 R8
   assign mask_clear = SYNC_LOSS_I || INTERNAL_RESET_I;

   // ====================================================================
   // second-level flags: set wins over clear, sync loss leaves them alone
   always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         late_response_flag <= 1'b0; // R14
         timeout_flag <= 1'b0;
      end else begin
         late_response_flag <= late_evt || (late_response_flag && !(wr_status_second && wbyte[POS_LATE])); // R9 R10
         timeout_flag <= timeout_evt || (timeout_flag && !(wr_status_second && wbyte[POS_TIMEOUT])); // R9 R10
      end
   end

   // ====================================================================
   // mask bits, cleared by internal reset or sync loss
   always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         combined_controller_irq_enable <= 1'b0;
         late_response_enable <= 1'b0;
         timeout_enable <= 1'b0;
      end else if (mask_clear) begin
         combined_controller_irq_enable <= 1'b0; // R4
         late_response_enable <= 1'b0; // R11
         timeout_enable <= 1'b0;
      end else begin
         if (wr_mask_first) begin
            combined_controller_irq_enable <= wbyte[POS_CTRL_IRQ];
         end
         if (wr_mask_second) begin
            late_response_enable <= wbyte[POS_LATE];
            timeout_enable <= wbyte[POS_TIMEOUT];
         end
      end
   end

   assign second_level_cascade_flag = (late_response_flag && late_response_enable)
                                      || (timeout_flag && timeout_enable); // R1 R11 R12
   assign combined_controller_irq_flag = CTRL_IRQ_I; // R2

   // ====================================================================
   // sticky pending: bit 0 gated controller irq, bit 1 cascade
   always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pending <= RST_EVT;
         enable <= RST_EVT;
      end else begin
         pending[0] <= (combined_controller_irq_flag && combined_controller_irq_enable) // R3
                       || (pending[0] && !(wr_pending && wbyte[0]));
         pending[1] <= second_level_cascade_flag || (pending[1] && !(wr_pending && wbyte[1]));
         if (wr_enable) begin
            enable <= wbyte[1:0];
         end
      end
   end

   always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= |(pending & enable);
      end
   end

   // ====================================================================
   // read wait state: data is captured one cycle into the data phase, so a
   // write whose data phase ends at the read's address edge is already seen
   always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rd_phase <= 1'b0;
      end else if (HREADY_I) begin
         rd_phase <= HSEL_I && HTRANS_I[1] && !HWRITE_I;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rd_ready <= 1'b0;
      end else begin
         rd_ready <= rd_phase && !rd_ready;
      end
   end

   assign rd_capture = rd_phase && !rd_ready;

   // ====================================================================
   // read data, reserved bits zero
   always_comb begin
      status_first = RST_REG8;
      status_first[POS_CASCADE] = second_level_cascade_flag;
      status_first[POS_CTRL_IRQ] = combined_controller_irq_flag;
      status_second = RST_REG8; // R14
      status_second[POS_LATE] = late_response_flag;
      status_second[POS_TIMEOUT] = timeout_flag;
      mask_first = RST_REG8;
      mask_first[POS_CTRL_IRQ] = combined_controller_irq_enable;
      mask_second = RST_REG8;
      mask_second[POS_LATE] = late_response_enable;
      mask_second[POS_TIMEOUT] = timeout_enable;
   end

   always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         HRDATA_O <= RDATA_ZERO;
      end else if (rd_capture && !aphase.valid) begin
         HRDATA_O <= RDATA_ZERO; // R14
      end else if (rd_capture) begin
         unique case (aphase.index)
            IDX_STATUS_FIRST: HRDATA_O <= {24'h00_0000, status_first};
            IDX_MASK_FIRST: HRDATA_O <= {24'h00_0000, mask_first};
            IDX_STATUS_SECOND: HRDATA_O <= {24'h00_0000, status_second};
            IDX_MASK_SECOND: HRDATA_O <= {24'h00_0000, mask_second};
            IDX_IRQ_PENDING: HRDATA_O <= {30'h0000_0000, pending};
            IDX_IRQ_ENABLE: HRDATA_O <= {30'h0000_0000, enable};
            default: HRDATA_O <= RDATA_ZERO;
         endcase
      end
   end

   // ====================================================================
   // checks
   cascade_value_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R1
      status_first[POS_CASCADE] == ((late_response_flag && late_response_enable) || (timeout_flag && timeout_enable)))
      else $error("cascade bit wrong");
   ctrl_follow_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R2
      status_first[POS_CTRL_IRQ] == CTRL_IRQ_I) else $error("controller irq bit wrong");
   ctrl_gate_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R3
      (CTRL_IRQ_I && combined_controller_irq_enable) |=> pending[0]) else $error("gated irq not pending");
   mask_clear_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R4
      mask_clear |=> !combined_controller_irq_enable && !late_response_enable) else $error("mask not cleared");
   late_set_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R5
      LAST_LATE_I |=> late_response_flag) else $error("late flag not set");
   timeout_set_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R7
      (BRIDGE_TIMEOUT_I && TIMEOUT_ENABLE_I) |=> timeout_flag) else $error("timeout flag not set");
   timeout_cfg_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R8
      (!timeout_flag && !TIMEOUT_ENABLE_I) |=> !timeout_flag) else $error("timeout set while disabled");
   flag_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R9
      (late_response_flag && !(wr_status_second && wbyte[POS_LATE])) |=> late_response_flag)
      else $error("late flag lost");
   sync_keep_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R10
      (timeout_flag && SYNC_LOSS_I && !wr_status_second) |=> timeout_flag) else $error("flag lost on sync loss");
   w1c_clear_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R9
      (wr_status_second && wbyte[POS_LATE] && !LAST_LATE_I) |=> !late_response_flag)
      else $error("late flag not cleared");
   reserved_zero_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R14
      status_first[6:1] == 6'h00 && status_second[7:3] == 5'h00 && mask_first[7:1] == 7'h00)
      else $error("reserved bit set");

   // ====================================================================
   // multi-step behaviour
   sequence late_seen_s;
      late_response_flag && late_response_enable;
   endsequence

   sequence timeout_seen_s;
      timeout_flag && timeout_enable;
   endsequence

   sequence ctrl_gated_s;
      CTRL_IRQ_I && combined_controller_irq_enable && enable[0] && !wr_enable;
   endsequence

   sequence irq_raise_s;
      pending[0] ##1 IRQ_O;
   endsequence

   sequence read_addr_s;
      HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I;
   endsequence

   sequence read_wait_s;
      !HREADYOUT_O ##1 HREADYOUT_O;
   endsequence

   cascade_late_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R1 R11
      late_seen_s |-> status_first[POS_CASCADE])
      else $error("late flag missing from cascade");
   cascade_timeout_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R1 R12
      timeout_seen_s |-> status_first[POS_CASCADE])
      else $error("timeout flag missing from cascade");
   cascade_quiet_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R1
      ((!late_response_flag || !late_response_enable) && (!timeout_flag || !timeout_enable)) |-> !status_first[POS_CASCADE])
      else $error("cascade set with nothing unmasked");
   timeout_gate_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R12
      (!timeout_enable && !late_response_flag) |-> !status_first[POS_CASCADE])
      else $error("masked timeout reached cascade");
   ctrl_block_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R3
      (!combined_controller_irq_enable && !pending[0]) |=> !pending[0])
      else $error("masked controller irq became pending");
   irq_path_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R3
      ctrl_gated_s |=> irq_raise_s)
      else $error("enabled controller irq did not reach the output");
   irq_level_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R3
      IRQ_O == $past(|(pending & enable)))
      else $error("irq output does not follow enabled pending bits");
   pending_clear_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R3
      (wr_pending && wbyte[0] && !(CTRL_IRQ_I && combined_controller_irq_enable)) |=> !pending[0])
      else $error("pending bit not cleared");
   mask_write_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R3
      (wr_mask_first && !mask_clear) |=> combined_controller_irq_enable == $past(wbyte[POS_CTRL_IRQ]))
      else $error("first mask write lost");
   late_mask_write_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R11
      (wr_mask_second && !mask_clear) |=> late_response_enable == $past(wbyte[POS_LATE]))
      else $error("late enable write lost");
   timeout_mask_write_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R12
      (wr_mask_second && !mask_clear) |=> timeout_enable == $past(wbyte[POS_TIMEOUT]))
      else $error("timeout enable write lost");
   late_keep_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R10
      (late_response_flag && SYNC_LOSS_I && !wr_status_second) |=> late_response_flag)
      else $error("late flag lost on sync loss");
   timeout_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R9
      (timeout_flag && !(wr_status_second && wbyte[POS_TIMEOUT])) |=> timeout_flag)
      else $error("timeout flag lost");
   timeout_clear_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R9
      (wr_status_second && wbyte[POS_TIMEOUT] && !timeout_evt) |=> !timeout_flag)
      else $error("timeout flag not cleared");
   reserved_second_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R14
      mask_second[7:3] == 5'h00 && !mask_second[0] && !status_second[0])
      else $error("reserved bit set in second level");
   read_wait_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
      read_addr_s |=> read_wait_s)
      else $error("read data phase timing wrong");
   read_zero_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // R14
      (rd_capture && !aphase.valid) |=> HRDATA_O == RDATA_ZERO)
      else $error("refused read returned data");
   read_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
      !rd_capture |=> $stable(HRDATA_O))
      else $error("read data changed outside capture");
endmodule
`default_nettype wire

// ===== verification/bgi_mgr.sv
/*
 bus manager model: single-word AHB-Lite reads and writes.
 assumes the slave's hreadyout comes back as hready_i on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bgi_mgr
   import bgi_pkg::*;
(
   input wire logic clk_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_i,
   output logic [31:0] haddr_o,
   output logic [1:0] htrans_o,
   output logic hwrite_o,
   output logic [31:0] hwdata_o,
   output logic [31:0] rdata_o,
   output int rcnt_o
);
   initial begin
      haddr_o = 32'h0000_0000;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hwdata_o = 32'h0000_0000;
      rdata_o = 32'h0000_0000;
   end
   // ====================================================================
   // one transfer; read data handed out with a count bump
   task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      haddr_o <= {22'h00_0000, idx, 2'b00};
      htrans_o <= HTRANS_NONSEQ;
      hwrite_o <= w;
      do @(posedge clk_i); while (hready_i !== 1'b1);
      htrans_o <= 2'h0;
      // unused data lines flip so a stale value never looks valid
      hwdata_o <= w ? d : ~hwdata_o;
      do @(posedge clk_i); while (hready_i !== 1'b1);
      if (!w) begin
         rdata_o <= hrdata_i;
         rcnt_o <= rcnt_o + 1;
      end
   endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
/*
 self-checking bench for the general interrupt status and mask block.
 assumes bgi_mgr as bus manager and event pulses driven from this bench.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
   import bgi_pkg::*;
;
   logic clk, rstn, hrdy, hresp, ctrl, ten, irq;
   logic [3:0] ev;
   logic [1:0] htrans;
   logic hwrite;
   logic [31:0] haddr, hwdata, hrdata, rdata, d, e;
   logic [31:0] q[$];
   int rcnt, fails, checks;
   bgi_top dut (.CLOCK_I(clk), .RSTN_I(rstn), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
      .HREADYOUT_O(hrdy), .HRESP_O(hresp), .CTRL_IRQ_I(ctrl), .LAST_LATE_I(ev[0]),
      .BRIDGE_TIMEOUT_I(ev[1]), .TIMEOUT_ENABLE_I(ten), .SYNC_LOSS_I(ev[2]),
      .INTERNAL_RESET_I(ev[3]), .IRQ_O(irq));
   bgi_mgr mgr (.clk_i(clk), .hready_i(hrdy), .hrdata_i(hrdata), .haddr_o(haddr), .htrans_o(htrans),
      .hwrite_o(hwrite), .hwdata_o(hwdata), .rdata_o(rdata), .rcnt_o(rcnt));
   // ====================================================================
   // read results against the oldest note
   always @(rcnt) begin
      e = q.pop_front();
      checks++;
      if (rdata !== e) begin
         fails++;
         $display("FAIL %0t read %h expected %h", $time, rdata, e);
      end
   end
   task automatic rd(input logic [7:0] i, input logic [31:0] x);
      q.push_back(x);
      mgr.xfer(i, 1'b0, 32'h0000_0000);
   endtask
   task automatic chk(input logic a, input logic x);
      #1;
      checks++;
      if (a !== x) begin
         fails++;
         $display("FAIL %0t flag %b", $time, a);
      end
   endtask
   task automatic pulse(input logic [3:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 4'h0;
   endtask
   task automatic final_report;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ====================================================================
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #50000;
      fails++;
      final_report;
   end
   initial begin
      rstn = 1'b0;
      ctrl = 1'b0;
      ten = 1'b0;
      ev = 4'h0;
      void'($urandom(81225));
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 7; i++) rd(IDX_STATUS_FIRST + 8'(i), 32'h0000_0000);
      chk(hresp, HRESP_OKAY);
      $display("test reset done");
      mgr.xfer(IDX_MASK_FIRST, 1'b1, 32'hFFFF_FFFF);
      rd(IDX_MASK_FIRST, 32'h0000_0001);
      ctrl <= 1'b1;
      mgr.xfer(IDX_IRQ_ENABLE, 1'b1, 32'h0000_0003);
      repeat (3) @(posedge clk);
      chk(irq, 1'b1);
      rd(IDX_STATUS_FIRST, 32'h0000_0001);
      mgr.xfer(IDX_MASK_FIRST, 1'b1, 32'h0000_0000);
      mgr.xfer(IDX_IRQ_PENDING, 1'b1, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
      @(posedge clk);
      ctrl <= 1'b0;
      rd(IDX_STATUS_FIRST, 32'h0000_0000);
      $display("test controller irq done");
      pulse(4'h1);
      rd(IDX_STATUS_SECOND, 32'h0000_0004);
      pulse(4'h2);
      rd(IDX_STATUS_SECOND, 32'h0000_0004);
      ten <= 1'b1;
      pulse(4'h2);
      rd(IDX_STATUS_SECOND, 32'h0000_0006);
      rd(IDX_STATUS_FIRST, 32'h0000_0000);
      mgr.xfer(IDX_MASK_SECOND, 1'b1, 32'h0000_0006);
      rd(IDX_STATUS_FIRST, 32'h0000_0080);
      rd(IDX_IRQ_PENDING, 32'h0000_0002);
      chk(irq, 1'b1);
      mgr.xfer(IDX_STATUS_SECOND, 1'b1, 32'h0000_0000);
      rd(IDX_STATUS_SECOND, 32'h0000_0006);
      mgr.xfer(IDX_MASK_FIRST, 1'b1, 32'h0000_0001);
      pulse(4'h4);
      rd(IDX_MASK_FIRST, 32'h0000_0000);
      rd(IDX_MASK_SECOND, 32'h0000_0000);
      rd(IDX_STATUS_SECOND, 32'h0000_0006);
      rd(IDX_STATUS_FIRST, 32'h0000_0000);
      mgr.xfer(IDX_IRQ_PENDING, 1'b1, 32'h0000_0002);
      rd(IDX_IRQ_PENDING, 32'h0000_0000);
      chk(irq, 1'b0);
      mgr.xfer(IDX_MASK_FIRST, 1'b1, 32'h0000_0001);
      pulse(4'h8);
      rd(IDX_MASK_FIRST, 32'h0000_0000);
      mgr.xfer(IDX_STATUS_SECOND, 1'b1, 32'h0000_0004);
      rd(IDX_STATUS_SECOND, 32'h0000_0002);
      mgr.xfer(IDX_MASK_SECOND, 1'b1, 32'h0000_0002);
      rd(IDX_STATUS_FIRST, 32'h0000_0080);
      mgr.xfer(IDX_MASK_SECOND, 1'b1, 32'h0000_0004);
      rd(IDX_STATUS_FIRST, 32'h0000_0000);
      $display("test second level done");
      repeat (4) begin
         d = $urandom;
         mgr.xfer(IDX_MASK_SECOND, 1'b1, d);
         rd(IDX_MASK_SECOND, d & 32'h0000_0006);
         mgr.xfer(IDX_MASK_FIRST, 1'b1, d);
         rd(IDX_MASK_FIRST, d & 32'h0000_0001);
      end
      $display("test random masks done");
      final_report;
   end
endmodule
`default_nettype wire
